// [pkg/hrs_pkg.sv]
// hrs_pkg: shared types and constants of the hardware return stack.
// assumes one system clock and a core that issues at most one stack
// operation per cycle.
package hrs_pkg;

  localparam int unsigned  DATA_W        = 16;
  localparam int unsigned  PTR_W         = 12;
  localparam logic [11:0]  PTR_RESET     = 12'hbf0;
  localparam logic [11:0]  PTR_STEP      = 12'h001;

  // stack operations; codes 1..3 store, 4..7 fetch
  typedef enum logic [2:0] {
    HRS_OP_IDLE          = 3'b000,
    HRS_OP_CALL          = 3'b001,
    HRS_OP_STORE         = 3'b010,
    HRS_OP_IRQ_VECTOR    = 3'b011,
    HRS_OP_SUBROUTINE_EXIT = 3'b100,
    HRS_OP_INTERRUPT_EXIT  = 3'b101,
    HRS_OP_LOAD          = 3'b110,
    HRS_OP_LOAD_IRQ_VAR  = 3'b111
  } hrs_op_t;

  // request from the core
  typedef struct packed {
    logic              valid;
    hrs_op_t           op;
    logic [15:0]       data;
  } hrs_req_t;

  // fetched word back to the core
  typedef struct packed {
    logic              valid;
    hrs_op_t           op;
    logic [15:0]       data;
  } hrs_rsp_t;

  function automatic logic hrs_is_store(input hrs_op_t op);
    return (op == HRS_OP_CALL) || (op == HRS_OP_STORE) ||
           (op == HRS_OP_IRQ_VECTOR);
  endfunction : hrs_is_store

  function automatic logic hrs_is_fetch(input hrs_op_t op);
    return op[2];
  endfunction : hrs_is_fetch

endpackage : hrs_pkg

// [hdl/hrs_stack.sv]
// hrs_stack: 16-bit return/data stack with its stack pointer.
// assumes the core drives req_i synchronous to clk_i, one op per cycle,
// and takes the fetched word from rsp_o one cycle after the request.
`timescale 1ns/1ns

// How it works
// - stack entries are sixteen bits, holding return addresses or data
// - call, subroutine exit, interrupt exit and irq vectoring use stack
// - explicit store and two load variants save and restore any value
// - reset loads the stack pointer with bf0h, the top of stack
// - store ops decrement the pointer, then write at the new pointer
// - fetch ops read at the pointer, then increment the pointer
module hrs_stack #(
  parameter int unsigned PTR_W = hrs_pkg::PTR_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire hrs_pkg::hrs_req_t req_i,
  output hrs_pkg::hrs_rsp_t      rsp_o,
  output logic [PTR_W-1:0]       stack_pointer_o
);

  // one entry per pointer value, so a wrapped pointer always lands
  // inside the array; the cost is the full array at the default width
  localparam int unsigned DEPTH = 1 << PTR_W;

  logic [hrs_pkg::DATA_W-1:0] stack_mem [DEPTH];
  logic [PTR_W-1:0]           stack_pointer_ff;
  logic [PTR_W-1:0]           nxt_stack_pointer;
  logic [PTR_W-1:0]           ptr_step;
  hrs_pkg::hrs_rsp_t          rsp_ff;
  logic                       do_store;
  logic                       do_fetch;

  // the step is cast once so both adders stay at pointer width
  assign ptr_step = PTR_W'(hrs_pkg::PTR_STEP);

  // decode; implicit and explicit ops share one path, so a call and an
  // explicit store differ only in the word they carry
  assign do_store = req_i.valid && hrs_pkg::hrs_is_store(req_i.op);
  assign do_fetch = req_i.valid && hrs_pkg::hrs_is_fetch(req_i.op);

  // pointer arithmetic wraps by width truncation; there is no full or
  // empty flag, so software alone must keep the stack within its depth
  always_comb begin
    nxt_stack_pointer = stack_pointer_ff;
    if (do_store) begin
      nxt_stack_pointer = PTR_W'(stack_pointer_ff - ptr_step);
    end else if (do_fetch) begin
      nxt_stack_pointer = PTR_W'(stack_pointer_ff + ptr_step);
    end
  end

  // stack pointer register; reset parks it at the top of the stack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_pointer_ff <= PTR_W'(hrs_pkg::PTR_RESET);
    end else begin
      stack_pointer_ff <= nxt_stack_pointer;
    end
  end

  // write lands at the already-decremented address; held off in reset
  // so a request that overlaps reset leaves no stray word behind
  always_ff @(posedge clk_i) begin
    if (do_store && !rst_i) begin
      stack_mem[nxt_stack_pointer] <= req_i.data;
    end
  end

  // fetch reads the current address before the increment takes effect;
  // memory has no reset, so unwritten entries read undefined
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= do_fetch;
      rsp_ff.op    <= do_fetch ? req_i.op : hrs_pkg::HRS_OP_IDLE;
      if (do_fetch) begin
        rsp_ff.data <= stack_mem[stack_pointer_ff];
      end
    end
  end

  // outputs come straight from flip-flops
  assign rsp_o           = rsp_ff;
  assign stack_pointer_o = stack_pointer_ff;

  // checks; all but the reset checks are cut off while reset is high, so
  // a request that overlaps reset is never judged
  chk_reset_top: assert property (
    @(posedge clk_i) rst_i |=>
      stack_pointer_ff == PTR_W'(hrs_pkg::PTR_RESET))
    else $error("stack pointer not at top after reset");

  chk_reset_quiet: assert property (
    @(posedge clk_i) rst_i |=> rsp_o == '0)
    else $error("answer not cleared by reset");

  chk_idle_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(do_store || do_fetch) |=> $stable(stack_pointer_ff) && !rsp_o.valid)
    else $error("pointer moved without an operation");

  // pointer movement: exactly one step per operation, in the direction
  // that the operation's kind asks for
  chk_store_dec: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_store |=> stack_pointer_ff ==
      PTR_W'($past(stack_pointer_ff) - ptr_step))
    else $error("store did not decrement the pointer");

  chk_fetch_inc: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_fetch |=> stack_pointer_ff ==
      PTR_W'($past(stack_pointer_ff) + ptr_step))
    else $error("fetch did not increment the pointer");

  chk_double_push: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_store ##1 do_store |=> stack_pointer_ff ==
      PTR_W'($past(stack_pointer_ff, 2) - ptr_step - ptr_step))
    else $error("two stores did not move the pointer by two");

  chk_call_dec: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.op == hrs_pkg::HRS_OP_CALL) |=>
    stack_pointer_ff == PTR_W'($past(stack_pointer_ff) - ptr_step))
    else $error("call did not decrement the pointer");

  chk_irq_dec: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.op == hrs_pkg::HRS_OP_IRQ_VECTOR) |=>
    stack_pointer_ff == PTR_W'($past(stack_pointer_ff) - ptr_step))
    else $error("irq vectoring did not decrement the pointer");

  chk_exit_inc: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.op inside {hrs_pkg::HRS_OP_SUBROUTINE_EXIT,
      hrs_pkg::HRS_OP_INTERRUPT_EXIT}) |=>
    stack_pointer_ff == PTR_W'($past(stack_pointer_ff) + ptr_step))
    else $error("exit did not increment the pointer");

  // answers: every fetch is answered one cycle later, and nothing else
  // raises or disturbs the answer
  chk_fetch_answer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_fetch |=> rsp_o.valid && rsp_o.op == $past(req_i.op))
    else $error("fetch not answered one cycle later");

  chk_load_variant: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.op inside {hrs_pkg::HRS_OP_LOAD,
      hrs_pkg::HRS_OP_LOAD_IRQ_VAR}) |=>
    rsp_o.valid && rsp_o.op == $past(req_i.op))
    else $error("load variant not answered");

  chk_store_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_store |=> !rsp_o.valid)
    else $error("store produced an answer");

  chk_answer_cause: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rsp_o.valid |-> $past(do_fetch))
    else $error("answer without a fetch one cycle earlier");

  chk_op_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rsp_o.valid |-> rsp_o.op == hrs_pkg::HRS_OP_IDLE)
    else $error("answer op set without an answer");

  chk_data_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !do_fetch |=> $stable(rsp_o.data))
    else $error("fetched word changed without a fetch");

  // round trips: a word comes back as it went in; the call, vectoring and
  // explicit store/load pairs also check that the pointer ends where it started
  chk_store_return: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_store ##1 do_fetch |=>
    rsp_o.data == $past(req_i.data, 2))
    else $error("word fetched differs from word stored");

  chk_call_exit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.op == hrs_pkg::HRS_OP_CALL) ##1
    (req_i.valid && req_i.op == hrs_pkg::HRS_OP_SUBROUTINE_EXIT) |=>
    rsp_o.data == $past(req_i.data, 2) &&
    stack_pointer_ff == $past(stack_pointer_ff, 2))
    else $error("call then exit did not restore address and pointer");

  chk_irq_exit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.op == hrs_pkg::HRS_OP_IRQ_VECTOR) ##1
    (req_i.valid && req_i.op == hrs_pkg::HRS_OP_INTERRUPT_EXIT) |=>
    rsp_o.data == $past(req_i.data, 2) &&
    stack_pointer_ff == $past(stack_pointer_ff, 2))
    else $error("vectoring then exit did not restore the word");

  chk_push_pop: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.op == hrs_pkg::HRS_OP_STORE) ##1
    (req_i.valid && req_i.op == hrs_pkg::HRS_OP_LOAD) |=>
    rsp_o.data == $past(req_i.data, 2) &&
    stack_pointer_ff == $past(stack_pointer_ff, 2))
    else $error("explicit store then load lost the word");

  chk_deep_return: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_store ##1 do_store ##1 do_fetch ##1 do_fetch |=>
    rsp_o.data == $past(req_i.data, 4))
    else $error("two-deep store and fetch lost the older word");

  // wrap in both directions, with nothing else to flag it
  chk_wrap_low: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_store && stack_pointer_ff == '0 |=> &stack_pointer_ff)
    else $error("pointer did not wrap on underflow");

  chk_wrap_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_fetch && &stack_pointer_ff |=> stack_pointer_ff == '0)
    else $error("pointer did not wrap on overflow");

endmodule : hrs_stack

// [testbench/hrs_core_model.sv]
// hrs_core_model: core side that issues one stack request per edge.
// assumes callers enter op_one just after a rising edge of clk_i.
`timescale 1ns/1ns
module hrs_core_model (
  input  wire logic         clk_i,
  output hrs_pkg::hrs_req_t req_o
);
  initial req_o = '0;
  // hold the request through the taking edge; idle drops valid
  task automatic op_one(input hrs_pkg::hrs_op_t op, input logic [15:0] d);
    req_o <= '{op != hrs_pkg::HRS_OP_IDLE, op, d};
    @(posedge clk_i);
  endtask : op_one
endmodule : hrs_core_model

// [testbench/test_hardware_return_stack.sv]
// test_hardware_return_stack: self-checking bench of the stack block.
// assumes the core model is the only driver of the request port.
`timescale 1ns/1ns
module test_hardware_return_stack;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  hrs_pkg::hrs_req_t req;
  hrs_pkg::hrs_rsp_t rsp;
  logic [11:0]       ptr;
  int                n_fail = 0;
  int                n_checks = 0;
  logic [15:0]       stk[$];
  logic [18:0]       expq[$];
  hrs_core_model i_core (.clk_i(clk_i), .req_o(req));
  hrs_stack i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp),
                   .stack_pointer_o(ptr));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk_word(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_ptr(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t pointer %h expected %h", $time, got, exp);
    end
  endtask : chk_ptr
  // every answer pulse must carry the oldest outstanding fetch
  always @(negedge clk_i) begin
    if (rsp.valid === 1'b1) begin
      chk_word({rsp.op, rsp.data}, expq.pop_front());
    end
  end
  // one op; the bench keeps its own stack image as the reference
  task automatic op(input hrs_pkg::hrs_op_t o, input logic [15:0] d);
    if (o[2]) begin
      expq.push_back({o, stk.pop_back()});
    end else begin
      stk.push_back(d);
    end
    i_core.op_one(o, d);
  endtask : op
  // idle one edge, look at the settled pointer, then return on an edge
  task automatic ptr_is(input logic [11:0] exp);
    i_core.op_one(hrs_pkg::HRS_OP_IDLE, 16'h0000);
    @(negedge clk_i);
    chk_ptr(ptr, exp);
    @(posedge clk_i);
  endtask : ptr_is
  // every store kind then every fetch kind, back to back
  task automatic t_order;
    op(hrs_pkg::HRS_OP_CALL, 16'h1234);
    op(hrs_pkg::HRS_OP_STORE, 16'hbeef);
    op(hrs_pkg::HRS_OP_IRQ_VECTOR, 16'h0f0f);
    op(hrs_pkg::HRS_OP_STORE, 16'hffff);
    ptr_is(12'hbec);
    for (int k = 4; k < 8; k++) begin
      op(hrs_pkg::hrs_op_t'(k), 16'h0000);
    end
    ptr_is(12'hbf0);
  endtask : t_order
  // store then fetch on back-to-back edges, pair by pair, then two deep
  task automatic t_back;
    op(hrs_pkg::HRS_OP_CALL, 16'h2468);
    op(hrs_pkg::HRS_OP_SUBROUTINE_EXIT, 16'h0000);
    op(hrs_pkg::HRS_OP_IRQ_VECTOR, 16'h1357);
    op(hrs_pkg::HRS_OP_INTERRUPT_EXIT, 16'h0000);
    op(hrs_pkg::HRS_OP_STORE, 16'ha5a5);
    op(hrs_pkg::HRS_OP_LOAD, 16'h0000);
    op(hrs_pkg::HRS_OP_STORE, 16'h5a5a);
    op(hrs_pkg::HRS_OP_STORE, 16'hc3c3);
    op(hrs_pkg::HRS_OP_LOAD_IRQ_VAR, 16'h0000);
    op(hrs_pkg::HRS_OP_LOAD, 16'h0000);
    ptr_is(12'hbf0);
  endtask : t_back
  // run the pointer down through zero and back up, no fault expected
  task automatic t_wrap;
    for (int i = 0; i <= 12'hbf0; i++) begin
      op(hrs_pkg::HRS_OP_STORE, 16'(i * 7));
    end
    ptr_is(12'hfff);
    op(hrs_pkg::HRS_OP_LOAD, 16'h0000);
    ptr_is(12'h000);
    chk_ptr(12'(expq.size()), 12'h000);
  endtask : t_wrap
  // reset in mid-run: pointer at the top, answer cleared, stack usable
  task automatic t_reset;
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk_ptr(ptr, 12'hbf0);
    chk_word({rsp.op, rsp.data}, 19'h0_0000);
    @(posedge clk_i);
    op(hrs_pkg::HRS_OP_CALL, 16'h0bad);
    op(hrs_pkg::HRS_OP_SUBROUTINE_EXIT, 16'h0000);
    ptr_is(12'hbf0);
  endtask : t_reset
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  // watchdog: the run needs about 3200 cycles, so allow five times that
  initial begin
    #64_000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk_ptr(ptr, 12'hbf0);
    @(posedge clk_i);
    t_order();
    t_back();
    t_wrap();
    t_reset();
    end_sim();
  end
endmodule : test_hardware_return_stack
